//--- logic/scr_pkg.sv
// constants for the system clock mode register and oscillator ready flags
// assumes a 40 MHz ref_clk and an APB register bus
package scr_pkg;
	// ==================================================
	// register map
	localparam logic [7:0] SCR_CLK_MODE_ADDR = 8'h00;
	localparam logic [7:0] SCR_HALT_CMD_ADDR = 8'h04;
	localparam logic [7:0] SCR_OSC_SEL_ADDR = 8'h08;
	localparam logic [7:0] SCR_SYS_STAT_ADDR = 8'h0C;
	// ==================================================
	// clock mode field positions and reset values
	localparam int SCR_DIV_LSB = 5;
	localparam int SCR_DIV_MSB = 7;
	localparam int SCR_UNIMP_BIT = 4;
	localparam int SCR_LTO_BIT = 3;
	localparam int SCR_HTO_BIT = 2;
	localparam int SCR_IDLEN_BIT = 1;
	localparam int SCR_HL_BIT = 0;
	localparam logic [2:0] SCR_DIV_RST = 3'h0;
	localparam logic SCR_IDLEN_RST = 1'b1;
	localparam logic SCR_HL_RST = 1'b1;
	localparam logic [31:0] SCR_UNMAPPED = 32'h0000_0000;
	// ==================================================
	// divider codes when the slow/fast select is low
	localparam logic [2:0] SCR_DIV_SUB0 = 3'h0;
	localparam logic [2:0] SCR_DIV_SUB1 = 3'h1;
	localparam logic [2:0] SCR_DIV_16 = 3'h4;
	// ==================================================
	// settle counts in slow clock cycles
	localparam int SCR_LXT_SETTLE = 1024;
	localparam int SCR_INTERNAL_SLOW_RC_OSC_SETTLE = 2;
	localparam logic [10:0] SCR_CNT_ONE = 11'h001;
	// ==================================================
	// power modes
	typedef enum logic [1:0] {
		SCR_RUN = 2'b00,
		SCR_IDLE1 = 2'b01,
		SCR_IDLE_CLOCK_STOPPED_MODE = 2'b11,
		SCR_SLEEP = 2'b10
	} scr_mode_e;
endpackage

//--- logic/scr_clock_ready.sv
// system clock mode register with divider select and oscillator ready flags
// assumes slow_tick and osc stable pins are async levels; wake pulse from the wake logic
//
// Local design decisions: the APB slave port and the register offsets.
`timescale 1ns/100ps
module scr_clock_ready (
	// clock and reset
	input wire logic ref_clk,
	input wire logic rst_n,
	// apb slave
	input wire logic psel,
	input wire logic penable,
	input wire logic pwrite,
	input wire logic [7:0] paddr,
	input wire logic [31:0] pwdata,
	output logic [31:0] prdata,
	output logic pready,
	output logic pslverr,
	// oscillator status pins
	input wire logic high_osc_stable,
	input wire logic slow_osc_tick,
	input wire logic wake_pulse,
	input wire logic fsys_on,
	// clock unit outputs
	output logic [2:0] sys_clk_div_sel,
	output logic clk_src_high_low_sel,
	output logic [6:0] sys_div_ratio,
	output logic cpu_run,
	output logic slow_clk_en,
	output logic fast_clk_en,
	output scr_pkg::scr_mode_e power_mode,
	output logic low_osc_ready_flag,
	output logic high_osc_ready_flag
);
	import scr_pkg::*;

	// ==================================================
	// synchronisers
	logic [1:0] hs_sync_q;
	logic [1:0] tick_sync_q;
	logic tick_prev_q;
	logic tick_rise;
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			hs_sync_q <= 2'b00;
			tick_sync_q <= 2'b00;
			tick_prev_q <= 1'b0;
		end else begin
			hs_sync_q <= {hs_sync_q[0], high_osc_stable};
			tick_sync_q <= {tick_sync_q[0], slow_osc_tick};
			tick_prev_q <= tick_sync_q[1];
		end
	end
	assign tick_rise = tick_sync_q[1] & ~tick_prev_q;

	// ==================================================
	// apb registers
	logic [2:0] div_sel_q;
	logic idle_en_q;
	logic hl_sel_q;
	logic use_lxt_q;
	logic halt_req;
	logic wr_en;
	logic lto_q;
	logic hto_q;
	scr_mode_e mode_q;
	assign wr_en = psel & penable & pwrite;
	assign halt_req = wr_en && paddr == SCR_HALT_CMD_ADDR;
	assign pready = 1'b1;
	assign pslverr = 1'b0;

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			div_sel_q <= SCR_DIV_RST;
			idle_en_q <= SCR_IDLEN_RST;
			hl_sel_q <= SCR_HL_RST;
			use_lxt_q <= 1'b0;
		end else if (wr_en) begin
			if (paddr == SCR_CLK_MODE_ADDR) begin
				// bit four has no storage
				div_sel_q <= pwdata[SCR_DIV_MSB:SCR_DIV_LSB];
				idle_en_q <= pwdata[SCR_IDLEN_BIT];
				hl_sel_q <= pwdata[SCR_HL_BIT];
			end else if (paddr == SCR_OSC_SEL_ADDR) begin
				use_lxt_q <= pwdata[0];
			end
		end
	end

	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			prdata <= SCR_UNMAPPED;
		end else if (psel && !penable && !pwrite) begin
			prdata <= SCR_UNMAPPED;
			unique case (paddr)
				SCR_CLK_MODE_ADDR: begin
					prdata[SCR_DIV_MSB:SCR_DIV_LSB] <= div_sel_q;
					prdata[SCR_UNIMP_BIT] <= 1'b0;
					prdata[SCR_LTO_BIT] <= lto_q;
					prdata[SCR_HTO_BIT] <= hto_q;
					prdata[SCR_IDLEN_BIT] <= idle_en_q;
					prdata[SCR_HL_BIT] <= hl_sel_q;
				end
				SCR_OSC_SEL_ADDR: prdata[0] <= use_lxt_q;
				SCR_SYS_STAT_ADDR: prdata[1:0] <= mode_q;
				default: prdata <= SCR_UNMAPPED;
			endcase
		end
	end

	// ==================================================
	// power mode
	always_ff @(posedge ref_clk) begin
		if (!rst_n) begin
			mode_q <= SCR_RUN;
		end else if (mode_q == SCR_RUN && halt_req) begin
			if (!idle_en_q) begin
				mode_q <= SCR_SLEEP;
			end else begin
				mode_q <= fsys_on ? SCR_IDLE1 : SCR_IDLE_CLOCK_STOPPED_MODE;
			end
		end else if (mode_q != SCR_RUN && wake_pulse) begin
			mode_q <= SCR_RUN;
		end
	end
	assign power_mode = mode_q;
	assign cpu_run = mode_q == SCR_RUN && hto_q;
	assign slow_clk_en = mode_q != SCR_SLEEP;
	assign fast_clk_en = mode_q == SCR_RUN || mode_q == SCR_IDLE1;

	// ==================================================
	// slow ready flag: counts slow ticks after reset or after leaving sleep
	logic [10:0] lto_cnt_q;
	logic [10:0] lto_target;
	assign lto_target = use_lxt_q ? 11'(SCR_LXT_SETTLE) : 11'(SCR_INTERNAL_SLOW_RC_OSC_SETTLE);
	always_ff @(posedge ref_clk) begin
		if (!rst_n || mode_q == SCR_SLEEP) begin
			lto_q <= 1'b0;
			lto_cnt_q <= '0;
		end else if (!lto_q && tick_rise) begin
			if (lto_cnt_q + SCR_CNT_ONE >= lto_target) begin
				lto_q <= 1'b1;
			end
			lto_cnt_q <= lto_cnt_q + SCR_CNT_ONE;
		end
	end

	// ==================================================
	// fast ready flag
	always_ff @(posedge ref_clk) begin
		if (!rst_n || mode_q == SCR_SLEEP || mode_q == SCR_IDLE_CLOCK_STOPPED_MODE) begin
			hto_q <= 1'b0;
		end else begin
			hto_q <= hs_sync_q[1];
		end
	end

	// ==================================================
	// divider ratio: ratio one means fast clock undivided, zero means slow source
	function automatic logic [6:0] scr_ratio(input logic hl, input logic [2:0] sel);
		logic [6:0] r;
		r = 7'h00;
		if (hl) begin
			r = 7'h01;
		end else if (sel != SCR_DIV_SUB0 && sel != SCR_DIV_SUB1) begin
			// shift by eight minus code: 010 gives 64, 100 gives 16, 111 gives 2
			r = 7'(7'h01 << (4'h8 - {1'b0, sel}));
		end
		return r;
	endfunction
	assign sys_div_ratio = scr_ratio(hl_sel_q, div_sel_q);
	assign sys_clk_div_sel = div_sel_q;
	assign clk_src_high_low_sel = hl_sel_q;
	assign low_osc_ready_flag = lto_q;
	assign high_osc_ready_flag = hto_q;

	// ==================================================
	// checks
	div16_code_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!hl_sel_q && div_sel_q == SCR_DIV_16) |-> sys_div_ratio == 7'h10) else $error("code 100 not divide by 16");
	unimp_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$past(psel && !penable && paddr == SCR_CLK_MODE_ADDR) |-> !prdata[SCR_UNIMP_BIT])
		else $error("bit four read nonzero");
	sleep_lto_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		mode_q == SCR_SLEEP |=> !lto_q) else $error("slow ready high in sleep");
	lto_wait_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$rose(lto_q) |-> lto_cnt_q >= lto_target - SCR_CNT_ONE) else $error("slow ready early");
	internal_slow_rc_osc_ready_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(!use_lxt_q && !lto_q && mode_q != SCR_SLEEP && lto_cnt_q == SCR_CNT_ONE && tick_rise) |=> lto_q)
		else $error("rc slow ready late");
	hto_idle_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode_q == SCR_SLEEP || mode_q == SCR_IDLE_CLOCK_STOPPED_MODE) |=> !hto_q) else $error("fast ready high while stopped");
	hto_follow_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode_q == SCR_RUN && hs_sync_q[1]) |=> hto_q) else $error("fast ready not raised");
	cpu_hto_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		cpu_run |-> hto_q) else $error("cpu runs before fast ready");
	halt_sleep_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode_q == SCR_RUN && halt_req && !idle_en_q) |=> mode_q == SCR_SLEEP && !slow_clk_en)
		else $error("halt did not sleep");
	ratio_range_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		sys_div_ratio <= 7'h40) else $error("ratio above 64");
	stopped_clk_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode_q == SCR_SLEEP || mode_q == SCR_IDLE_CLOCK_STOPPED_MODE) |-> !fast_clk_en && !cpu_run)
		else $error("fast clock runs while stopped");
	wake_run_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		(mode_q != SCR_RUN && wake_pulse) |=> mode_q == SCR_RUN)
		else $error("wake did not return to run");
	status_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$past(psel && !penable && !pwrite && paddr == SCR_SYS_STAT_ADDR) |-> prdata[1:0] == $past(mode_q))
		else $error("status read wrong mode");
	hto_read_a: assert property (@(posedge ref_clk) disable iff (!rst_n)
		$past(psel && !penable && !pwrite && paddr == SCR_CLK_MODE_ADDR) |-> prdata[SCR_HTO_BIT] == $past(hto_q))
		else $error("fast ready read wrong");
endmodule

//--- dv/test_system_clock_ready_flags.sv
// self-checking bench for the clock mode register and oscillator ready flags
// assumes scr_clock_ready with its apb slave at zero wait states
`timescale 1ns/100ps
module test_system_clock_ready_flags;
	import scr_pkg::*;
	// ==================================================
	// stimulus and observation
	logic ref_clk = 1'b0;
	logic rst_n = 1'b0;
	logic psel = 1'b0;
	logic penable = 1'b0;
	logic pwrite = 1'b0;
	logic [7:0] paddr = 8'h00;
	logic [31:0] pwdata = 32'h0;
	logic high_osc_stable = 1'b0;
	logic slow_osc_tick = 1'b0;
	logic wake_pulse = 1'b0;
	logic fsys_on = 1'b0;
	logic [31:0] prdata, r, wd, seed;
	logic pready, pslverr, clk_src_high_low_sel, cpu_run, slow_clk_en, fast_clk_en;
	logic low_osc_ready_flag, high_osc_ready_flag;
	logic [2:0] sys_clk_div_sel;
	logic [6:0] sys_div_ratio;
	scr_mode_e power_mode;
	int n_mismatch = 0;
	int compares = 0;
	int cyc = 0;
	always #12.5 ref_clk = ~ref_clk;
	scr_clock_ready u_dut (.ref_clk(ref_clk), .rst_n(rst_n), .psel(psel), .penable(penable), .pwrite(pwrite),
		.paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
		.high_osc_stable(high_osc_stable), .slow_osc_tick(slow_osc_tick), .wake_pulse(wake_pulse),
		.fsys_on(fsys_on), .sys_clk_div_sel(sys_clk_div_sel), .clk_src_high_low_sel(clk_src_high_low_sel),
		.sys_div_ratio(sys_div_ratio), .cpu_run(cpu_run), .slow_clk_en(slow_clk_en), .fast_clk_en(fast_clk_en),
		.power_mode(power_mode), .low_osc_ready_flag(low_osc_ready_flag), .high_osc_ready_flag(high_osc_ready_flag));
	// ==================================================
	// helpers
	function automatic logic [6:0] exp_ratio(input logic hl, input logic [2:0] code);
		if (hl) return 7'h01;
		if (code < 3'h2) return 7'h00;
		return 7'h01 << (4'h8 - {1'b0, code});
	endfunction
	task automatic pause(input int n);
		repeat (n) @(posedge ref_clk);
	endtask
	task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string msg);
		compares++;
		if (got !== exp) begin
			n_mismatch++;
			$display("[ERR] %0t %s got %h exp %h", $time, msg, got, exp);
		end
	endtask
	// holds the whole request until pready is seen high or 50 cycles pass
	task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] rd);
		int t;
		t = 0;
		@(posedge ref_clk);
		psel <= 1'b1;
		pwrite <= w;
		paddr <= a;
		pwdata <= d;
		@(posedge ref_clk);
		penable <= 1'b1;
		do begin
			@(posedge ref_clk);
			t++;
		end while (pready !== 1'b1 && t < 50);
		rd = prdata;
		psel <= 1'b0;
		penable <= 1'b0;
	endtask
	// slow cycles: each lasts four ref cycles, clock stands still between bursts
	task automatic tick(input int n);
		repeat (n) begin
			slow_osc_tick <= 1'b1;
			pause(2);
			slow_osc_tick <= 1'b0;
			pause(2);
		end
	endtask
	task automatic wake();
		wake_pulse <= 1'b1;
		pause(1);
		wake_pulse <= 1'b0;
	endtask
	task automatic close_out();
		$display("mismatches %0d compares %0d", n_mismatch, compares);
		if (n_mismatch == 0 && compares > 0) $display("All checks passed");
		else $display("Checks failed");
		$finish;
	endtask
	always @(posedge ref_clk) begin
		cyc++;
		if (cyc == 20000) begin
			n_mismatch++;
			close_out();
		end
	end
	// ==================================================
	// scenarios
	initial begin
		seed = 32'h3EA3;
		pause(3);
		rst_n <= 1'b1;
		apb(1'b0, SCR_CLK_MODE_ADDR, 32'h0, r);
		chk(r, 32'h0000_0003, "reset value");
		chk(low_osc_ready_flag, 1'b0, "slow flag before ticks");
		chk(high_osc_ready_flag, 1'b0, "fast flag at power on");
		chk(pslverr, 1'b0, "no slave error");
		high_osc_stable <= 1'b1;
		tick(2);
		pause(6);
		apb(1'b0, SCR_CLK_MODE_ADDR, 32'h0, r);
		chk(r[3:2], 2'h3, "flags after settle");
		chk(cpu_run, 1'b1, "cpu runs once fast ready");
		$display("test reset done");
		for (int i = 0; i < 24; i++) begin
			wd = $random(seed);
			if (i < 8) wd[7:5] = i[2:0];
			if (i < 8) wd[0] = 1'b0;
			apb(1'b1, SCR_CLK_MODE_ADDR, wd, r);
			apb(1'b0, SCR_CLK_MODE_ADDR, 32'h0, r);
			chk(r & 32'hF3, wd & 32'hE3, "mode readback");
			chk(sys_div_ratio, exp_ratio(wd[0], wd[7:5]), "divide ratio");
			chk({clk_src_high_low_sel, sys_clk_div_sel}, {wd[0], wd[7:5]}, "select outputs");
		end
		apb(1'b1, 8'h10, 32'hFFFF_FFFF, r);
		apb(1'b0, 8'h10, 32'h0, r);
		chk(r, SCR_UNMAPPED, "unmapped read");
		$display("test divider done");
		apb(1'b1, SCR_OSC_SEL_ADDR, 32'h1, r);
		apb(1'b1, SCR_CLK_MODE_ADDR, 32'h0, r);
		apb(1'b1, SCR_HALT_CMD_ADDR, 32'h0, r);
		pause(3);
		chk(power_mode, SCR_SLEEP, "halt into sleep");
		chk({low_osc_ready_flag, high_osc_ready_flag, cpu_run}, 3'h0, "sleep flags");
		chk({slow_clk_en, fast_clk_en}, 2'h0, "sleep clocks");
		wake();
		tick(1023);
		pause(8);
		chk(low_osc_ready_flag, 1'b0, "crystal flag early");
		tick(1);
		pause(8);
		chk({low_osc_ready_flag, high_osc_ready_flag}, 2'h3, "flags after wake");
		$display("test sleep done");
		for (int f = 0; f < 2; f++) begin
			fsys_on <= f[0];
			apb(1'b1, SCR_CLK_MODE_ADDR, 32'h2, r);
			apb(1'b1, SCR_HALT_CMD_ADDR, 32'h0, r);
			pause(4);
			chk(power_mode, f ? SCR_IDLE1 : SCR_IDLE_CLOCK_STOPPED_MODE, "idle mode");
			chk(high_osc_ready_flag, f[0], "fast flag in idle");
			chk(fast_clk_en, f[0], "fast clock in idle");
			apb(1'b0, SCR_SYS_STAT_ADDR, 32'h0, r);
			chk(r, 32'(f ? SCR_IDLE1 : SCR_IDLE_CLOCK_STOPPED_MODE), "status read");
			wake();
			pause(6);
			chk(high_osc_ready_flag, 1'b1, "fast flag after idle");
		end
		$display("test idle done");
		close_out();
	end
endmodule
